// >>> logic/uec_pkg.sv
/*
  Constants for the asynchronous serial transmitter: register offsets,
  field positions, reset values and format encodings.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package uec_pkg;
  // Register byte offsets
  localparam logic [7:0] UEC_MODE_OFS = 8'h00;
  localparam logic [7:0] UEC_STAT_OFS = 8'h04;
  localparam logic [7:0] UEC_TXD_OFS = 8'h08;
  localparam logic [7:0] UEC_RATE_OFS = 8'h0C;
  localparam logic [7:0] UEC_DIR_OFS = 8'h10;
  localparam logic [7:0] UEC_LAT_OFS = 8'h14;
  localparam logic [7:0] UEC_PIN_OFS = 8'h18;

  // Mode register fields
  localparam int UEC_M_ON = 15;
  localparam int UEC_M_ALT = 10;
  localparam int UEC_M_FMT_HI = 2;
  localparam int UEC_M_FMT_LO = 1;
  localparam int UEC_M_STOP = 0;

  // Status and control register fields
  localparam int UEC_S_TXISEL = 15;
  localparam int UEC_S_BRK = 11;
  localparam int UEC_S_TXEN = 10;
  localparam int UEC_S_FULL = 9;
  localparam int UEC_S_SHIFTER_EMPTY_FLAG = 8;
  localparam int UEC_S_RXISEL_HI = 7;
  localparam int UEC_S_RXISEL_LO = 6;
  localparam int UEC_S_ADDRESS_MATCH_ENABLE = 5;
  localparam int UEC_S_RECEIVER_QUIET_FLAG = 4;

  // Pin index in the direction, latch and pin-level registers
  localparam int UEC_P_TX = 0;
  localparam int UEC_P_RX = 1;
  localparam int UEC_P_ATX = 2;
  localparam int UEC_P_ARX = 3;
  localparam int UEC_NPINS = 4;

  // Reset values
  localparam logic [15:0] UEC_MODE_RST = 16'h0000;
  localparam logic [15:0] UEC_RATE_RST = 16'h0000;
  localparam logic [3:0] UEC_DIR_RST = 4'hF;
  localparam logic [3:0] UEC_LAT_RST = 4'h0;

  // Timing: sub-bit ticks per bit
  localparam int UEC_OVERSAMPLE = 16;
  localparam logic [3:0] UEC_TICK_LAST = 4'(UEC_OVERSAMPLE - 1);

  typedef enum logic [1:0] {
    UEC_FMT_8N,
    UEC_FMT_8E,
    UEC_FMT_8O,
    UEC_FMT_9N
  } uec_fmt_e;
endpackage : uec_pkg

// >>> logic/uec_uart_tx.sv
/*
  Asynchronous serial port, transmit side: module enable, pin selection,
  frame format, four-entry transmit queue, transmit interrupt pulse and
  break. Registers sit on a classic Wishbone slave.
  Assumes the pins are resolved outside from out/oe, and that pin inputs
  are asynchronous to clk_i.
*/
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module uec_uart_tx #(
  parameter int QDEPTH = 4,
  parameter int DATA_W = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_out_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  input wire logic serial_in_pin_i,
  output logic serial_in_pin_o,
  output logic serial_in_pin_oe_o,
  input wire logic alt_serial_out_pin_i,
  output logic alt_serial_out_pin_o,
  output logic alt_serial_out_pin_oe_o,
  input wire logic alt_serial_in_pin_i,
  output logic alt_serial_in_pin_o,
  output logic alt_serial_in_pin_oe_o,
  output logic transmit_irq_o
);
  import uec_pkg::*;

  localparam int CW = $clog2(QDEPTH + 1);
  localparam int PW = (QDEPTH > 1) ? $clog2(QDEPTH) : 1;
  localparam logic [CW-1:0] QFULL = CW'(QDEPTH);
  localparam logic [CW-1:0] QONE = CW'(1);

  if (QDEPTH < 1 || (QDEPTH & (QDEPTH - 1)) != 0 || DATA_W != 9)
  begin : g_bad_param
    $error("uec_uart_tx: QDEPTH must be a power of two, DATA_W must be 9");
  end

  typedef enum logic [2:0] {
    UEC_IDLE,
    UEC_START,
    UEC_DATA,
    UEC_PAR,
    UEC_STOP
  } uec_state_e;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
    begin
      r[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction : merge16

  // Bus request decode
  logic req;
  logic wr;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;

  // Software-visible state
  logic [15:0] mode_register;
  logic [15:0] rate_divider_register;
  logic transmit_irq_select;
  logic break_force_bit;
  logic transmit_permit_bit;
  logic [1:0] receive_irq_select;
  logic address_match_enable;
  logic [UEC_NPINS-1:0] pin_direction_reg;
  logic [UEC_NPINS-1:0] port_output_reg;

  logic module_on_bit;
  logic alternate_pin_select;
  uec_fmt_e format_select_field;
  logic stop_count_select;
  assign module_on_bit = mode_register[UEC_M_ON];
  assign alternate_pin_select = mode_register[UEC_M_ALT];
  assign format_select_field = uec_fmt_e'(mode_register[UEC_M_FMT_HI:UEC_M_FMT_LO]);
  assign stop_count_select = mode_register[UEC_M_STOP];

  // Transmit queue
  logic [DATA_W-1:0] transmit_queue [QDEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] q_count;
  logic transmit_queue_full;
  logic push;
  logic pop;
  assign transmit_queue_full = (q_count == QFULL);

  // Shifter
  uec_state_e state;
  logic [DATA_W-1:0] transmit_shifter;
  logic [3:0] bit_idx;
  logic [3:0] data_last;
  logic par_bit;
  logic stop_second;
  logic shifter_empty_flag;
  assign shifter_empty_flag = (state == UEC_IDLE);

  // Bit timing
  logic [15:0] div_cnt;
  logic [3:0] tick_cnt;
  logic bit_end;
  assign bit_end = (div_cnt == rate_divider_register) && (tick_cnt == UEC_TICK_LAST);

  // Pin input synchronisers
  logic [UEC_NPINS-1:0] pin_meta;
  logic [UEC_NPINS-1:0] pin_sync;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {alt_serial_in_pin_i, alt_serial_out_pin_i, serial_in_pin_i,
                   serial_out_pin_i};
      pin_sync <= pin_meta;
    end
  end

  // Mode, rate divider and port registers: kept across disable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_register <= UEC_MODE_RST;
      rate_divider_register <= UEC_RATE_RST;
      pin_direction_reg <= UEC_DIR_RST;
      port_output_reg <= UEC_LAT_RST;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        UEC_MODE_OFS: mode_register <= merge16(mode_register, wb_dat_i, wb_sel_i);
        UEC_RATE_OFS:
          rate_divider_register <= merge16(rate_divider_register, wb_dat_i, wb_sel_i);
        UEC_DIR_OFS:
          if (wb_sel_i[0])
          begin
            pin_direction_reg <= wb_dat_i[UEC_NPINS-1:0];
          end
        UEC_LAT_OFS:
          if (wb_sel_i[0])
          begin
            port_output_reg <= wb_dat_i[UEC_NPINS-1:0];
          end
        default: ;
      endcase
    end
  end

  // Status control bits; enable and break are cleared while off
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      transmit_irq_select <= 1'b0;
      break_force_bit <= 1'b0;
      transmit_permit_bit <= 1'b0;
      receive_irq_select <= 2'h0;
      address_match_enable <= 1'b0;
    end
    else
    begin
      if (wr && wb_adr_i == UEC_STAT_OFS && wb_sel_i[1])
      begin
        transmit_irq_select <= wb_dat_i[UEC_S_TXISEL];
        break_force_bit <= wb_dat_i[UEC_S_BRK];
        transmit_permit_bit <= wb_dat_i[UEC_S_TXEN];
      end
      if (wr && wb_adr_i == UEC_STAT_OFS && wb_sel_i[0])
      begin
        receive_irq_select <= wb_dat_i[UEC_S_RXISEL_HI:UEC_S_RXISEL_LO];
        address_match_enable <= wb_dat_i[UEC_S_ADDRESS_MATCH_ENABLE];
      end
      if (!module_on_bit)
      begin
        break_force_bit <= 1'b0;
        transmit_permit_bit <= 1'b0;
      end
    end
  end

  // Queue: push on a data write with room, pop into a free shifter
  assign push = wr && wb_adr_i == UEC_TXD_OFS && module_on_bit && !transmit_queue_full
                && wb_sel_i[0];
  assign pop = module_on_bit && transmit_permit_bit && !break_force_bit
               && shifter_empty_flag && q_count != '0;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      transmit_queue[wr_ptr] <= wb_sel_i[1] ? wb_dat_i[DATA_W-1:0]
                                            : {transmit_queue[wr_ptr][DATA_W-1], wb_dat_i[7:0]};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !module_on_bit)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      q_count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + PW'(1);
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + PW'(1);
      end
      case ({push, pop})
        2'b10: q_count <= q_count + QONE;
        2'b01: q_count <= q_count - QONE;
        default: q_count <= q_count;
      endcase
    end
  end

  // Transmit interrupt pulse on a queue-to-shifter transfer; with transmit_irq_select set, only on the transfer that empties the queue
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      transmit_irq_o <= 1'b0;
    end
    else
    begin
      transmit_irq_o <= pop && (!transmit_irq_select || (q_count == QONE && !push));
    end
  end

  // Rate counters run only while a frame is on the line, so a load starts
  // its start bit at once instead of waiting out a stale bit period.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !module_on_bit || shifter_empty_flag)
    begin
      div_cnt <= '0;
      tick_cnt <= '0;
    end
    else if (div_cnt == rate_divider_register)
    begin
      div_cnt <= '0;
      tick_cnt <= tick_cnt + 4'h1;
    end
    else
    begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // Frame sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !module_on_bit)
    begin
      state <= UEC_IDLE;
      transmit_shifter <= '0;
      bit_idx <= '0;
      data_last <= 4'h7;
      par_bit <= 1'b0;
      stop_second <= 1'b0;
    end
    else
    begin
      case (state)
        UEC_IDLE:
          if (pop)
          begin
            transmit_shifter <= transmit_queue[rd_ptr];
            data_last <= (format_select_field == UEC_FMT_9N) ? 4'h8 : 4'h7;
            par_bit <= ^transmit_queue[rd_ptr][7:0] ^ (format_select_field == UEC_FMT_8O);
            bit_idx <= '0;
            stop_second <= 1'b0;
            state <= UEC_START;
          end
        UEC_START:
          if (bit_end)
          begin
            state <= UEC_DATA;
          end
        UEC_DATA:
          if (bit_end)
          begin
            transmit_shifter <= transmit_shifter >> 1;
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == data_last)
            begin
              state <= (format_select_field == UEC_FMT_8E || format_select_field == UEC_FMT_8O)
                       ? UEC_PAR : UEC_STOP;
            end
          end
        UEC_PAR:
          if (bit_end)
          begin
            state <= UEC_STOP;
          end
        UEC_STOP:
          if (bit_end)
          begin
            if (stop_count_select && !stop_second)
            begin
              stop_second <= 1'b1;
            end
            else
            begin
              state <= UEC_IDLE;
            end
          end
        default: state <= UEC_IDLE;
      endcase
    end
  end

  // Serial line level and pin ownership
  logic line_level;
  always_comb
  begin
    case (state)
      UEC_START: line_level = 1'b0;
      UEC_DATA: line_level = transmit_shifter[0];
      UEC_PAR: line_level = par_bit;
      default: line_level = 1'b1;
    endcase
    if (break_force_bit)
    begin
      line_level = 1'b0;
    end
  end

  logic [UEC_NPINS-1:0] next_pin_out;
  logic [UEC_NPINS-1:0] next_pin_oe;
  always_comb
  begin
    next_pin_out = port_output_reg;
    next_pin_oe = ~pin_direction_reg;
    if (module_on_bit)
    begin
      if (alternate_pin_select)
      begin
        next_pin_out[UEC_P_ATX] = line_level;
        next_pin_oe[UEC_P_ATX] = 1'b1;
        next_pin_oe[UEC_P_ARX] = 1'b0;
      end
      else
      begin
        next_pin_out[UEC_P_TX] = line_level;
        next_pin_oe[UEC_P_TX] = 1'b1;
        next_pin_oe[UEC_P_RX] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      serial_out_pin_o <= 1'b0;
      serial_out_pin_oe_o <= 1'b0;
      serial_in_pin_o <= 1'b0;
      serial_in_pin_oe_o <= 1'b0;
      alt_serial_out_pin_o <= 1'b0;
      alt_serial_out_pin_oe_o <= 1'b0;
      alt_serial_in_pin_o <= 1'b0;
      alt_serial_in_pin_oe_o <= 1'b0;
    end
    else
    begin
      serial_out_pin_o <= next_pin_out[UEC_P_TX];
      serial_out_pin_oe_o <= next_pin_oe[UEC_P_TX];
      serial_in_pin_o <= next_pin_out[UEC_P_RX];
      serial_in_pin_oe_o <= next_pin_oe[UEC_P_RX];
      alt_serial_out_pin_o <= next_pin_out[UEC_P_ATX];
      alt_serial_out_pin_oe_o <= next_pin_oe[UEC_P_ATX];
      alt_serial_in_pin_o <= next_pin_out[UEC_P_ARX];
      alt_serial_in_pin_oe_o <= next_pin_oe[UEC_P_ARX];
    end
  end

  // Status read view; receive side is absent, so its flags rest at the
  // values a disabled receiver shows.
  logic [15:0] status_view;
  always_comb
  begin
    status_view = 16'h0000;
    status_view[UEC_S_TXISEL] = transmit_irq_select;
    status_view[UEC_S_BRK] = break_force_bit;
    status_view[UEC_S_TXEN] = transmit_permit_bit;
    status_view[UEC_S_FULL] = transmit_queue_full;
    status_view[UEC_S_SHIFTER_EMPTY_FLAG] = shifter_empty_flag;
    status_view[UEC_S_RXISEL_HI:UEC_S_RXISEL_LO] = receive_irq_select;
    status_view[UEC_S_ADDRESS_MATCH_ENABLE] = address_match_enable;
    status_view[UEC_S_RECEIVER_QUIET_FLAG] = 1'b1;
  end

  // Wishbone answer: one cycle after the request, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && !wb_we_i)
      begin
        case (wb_adr_i)
          UEC_MODE_OFS: wb_dat_o <= {16'h0000, mode_register};
          UEC_STAT_OFS: wb_dat_o <= {16'h0000, status_view};
          UEC_RATE_OFS: wb_dat_o <= {16'h0000, rate_divider_register};
          UEC_DIR_OFS: wb_dat_o <= {28'h0000000, pin_direction_reg};
          UEC_LAT_OFS: wb_dat_o <= {28'h0000000, port_output_reg};
          UEC_PIN_OFS: wb_dat_o <= {28'h0000000, pin_sync};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : uec_uart_tx

// >>> verification/uec_uart_tx_properties.sv
/*
  Checker for the serial transmitter: bus answer, pin ownership, break and interrupt timing.
  Assumes a master that holds each request until ack, as the bench does.
*/
`timescale 1ns/1ps
module uec_uart_tx_chk
  import uec_pkg::*;
#(
  parameter int QDEPTH = 4,
  parameter int DATA_W = 9
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_o,
  input wire logic serial_in_pin_oe_o,
  input wire logic alt_serial_out_pin_oe_o,
  input wire logic alt_serial_in_pin_oe_o,
  input wire logic transmit_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic take;
  logic on_q;
  logic alt_q;
  logic brk_q;
  // Shadow of the control bits, updated at the edge that takes the write
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[1];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      on_q <= 1'b0;
      alt_q <= 1'b0;
    end
    else if (take && wb_adr_i == UEC_MODE_OFS)
    begin
      on_q <= wb_dat_i[UEC_M_ON];
      alt_q <= wb_dat_i[UEC_M_ALT];
    end
  end
  // Break cannot be set while off, and turning off clears it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      brk_q <= 1'b0;
    else if (take && wb_adr_i == UEC_MODE_OFS && !wb_dat_i[UEC_M_ON])
      brk_q <= 1'b0;
    else if (take && wb_adr_i == UEC_STAT_OFS)
      brk_q <= on_q && wb_dat_i[UEC_S_BRK];
  end
  sequence off_two;
    !on_q ##1 !on_q;
  endsequence
  chk_reset_pins_off: assert property (disable iff (1'b0) rst_i |=>
    !serial_out_pin_oe_o && !alt_serial_out_pin_oe_o && !wb_ack_o)
    else $error("pins or ack active after reset");
  chk_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_on_primary_pins: assert property (on_q && !alt_q |=>
    serial_out_pin_oe_o && !serial_in_pin_oe_o)
    else $error("primary pins not owned while on");
  chk_on_alt_pins: assert property (on_q && alt_q |=>
    alt_serial_out_pin_oe_o && !alt_serial_in_pin_oe_o && !serial_out_pin_oe_o)
    else $error("alternate pins not owned");
  chk_break_line_low: assert property (on_q && brk_q && !alt_q |=> !serial_out_pin_o)
    else $error("line not low during break");
  chk_break_no_irq: assert property (brk_q ##1 brk_q |=> !transmit_irq_o)
    else $error("irq during break");
  chk_off_no_irq: assert property (off_two |=> !transmit_irq_o)
    else $error("irq while off");
  chk_irq_start_bit: assert property (transmit_irq_o && on_q && !alt_q |->
    ##[0:1] !serial_out_pin_o)
    else $error("no start bit with transfer");
  cover property (transmit_irq_o && on_q);
  cover property (on_q && brk_q);
  cover property (on_q && alt_q && transmit_irq_o);
endmodule : uec_uart_tx_chk

bind uec_uart_tx uec_uart_tx_chk #(.QDEPTH(QDEPTH), .DATA_W(DATA_W)) i_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o),
  .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe_o(serial_out_pin_oe_o),
  .serial_in_pin_oe_o(serial_in_pin_oe_o),
  .alt_serial_out_pin_oe_o(alt_serial_out_pin_oe_o),
  .alt_serial_in_pin_oe_o(alt_serial_in_pin_oe_o),
  .transmit_irq_o(transmit_irq_o)
);

// >>> verification/uec_rx_model.sv
/*
  Remote serial receiver: samples each bit in its middle and checks parity and stops.
  Assumes the line is pulled high when no one drives it.
*/
`timescale 1ns/1ps
module uec_rx_model (
  input wire logic clk_i,
  input wire logic line_i,
  input int bit_clks_i,
  input int nbits_i,
  input int par_i,
  input int stops_i,
  output logic [8:0] data_o,
  output int count_o,
  output int err_o
);
  logic [8:0] d;
  initial
  begin
    count_o = 0;
    err_o = 0;
    data_o = '0;
  end
  // A short glitch low is not taken as a start bit
  always
  begin
    @(negedge line_i);
    @(posedge clk_i);
    if (line_i === 1'b0)
      repeat (bit_clks_i / 2 - 1) @(posedge clk_i);
    if (line_i === 1'b0)
    begin
      d = '0;
      for (int i = 0; i < nbits_i; i++)
      begin
        repeat (bit_clks_i) @(posedge clk_i);
        d[i] = line_i;
      end
      if (par_i != 0)
      begin
        repeat (bit_clks_i) @(posedge clk_i);
        if ((^d ^ line_i) !== (par_i == 2))
          err_o++;
      end
      for (int i = 0; i < stops_i; i++)
      begin
        repeat (bit_clks_i) @(posedge clk_i);
        if (line_i !== 1'b1)
          err_o++;
      end
      data_o = d;
      count_o++;
    end
  end
endmodule : uec_rx_model

// >>> verification/uart_enable_config_transmit_tb_top.sv
/*
  Testbench for the serial transmitter: registers over Wishbone, frames seen by a remote receiver.
  Assumes pull-ups on all four pins and a receive line held idle by the far side.
*/
`timescale 1ns/1ps
module uart_enable_config_transmit_tb_top;
  import uec_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic wb_ack_o, transmit_irq_o, tx_o, tx_oe, rx_o, rx_oe, atx_o, atx_oe, arx_o, arx_oe;
  wire logic tx_w = tx_oe ? tx_o : 1'b1;
  wire logic rx_w = rx_oe ? rx_o : 1'b1;
  wire logic atx_w = atx_oe ? atx_o : 1'b1;
  wire logic arx_w = arx_oe ? arx_o : 1'b1;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int irqs = 0;
  int bit_clks = 16;
  int nbits = 8;
  int par = 0;
  int stops = 1;
  int rx_count, rx_err, base;
  logic [8:0] rx_data;
  always #2.5 clk_i = ~clk_i;
  uec_uart_tx i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_out_pin_i(tx_w), .serial_out_pin_o(tx_o),
    .serial_out_pin_oe_o(tx_oe), .serial_in_pin_i(rx_w), .serial_in_pin_o(rx_o),
    .serial_in_pin_oe_o(rx_oe), .alt_serial_out_pin_i(atx_w), .alt_serial_out_pin_o(atx_o),
    .alt_serial_out_pin_oe_o(atx_oe), .alt_serial_in_pin_i(arx_w), .alt_serial_in_pin_o(arx_o),
    .alt_serial_in_pin_oe_o(arx_oe), .transmit_irq_o(transmit_irq_o));
  uec_rx_model i_far (.clk_i(clk_i), .line_i(tx_w & atx_w), .bit_clks_i(bit_clks),
    .nbits_i(nbits), .par_i(par), .stops_i(stops), .data_o(rx_data), .count_o(rx_count),
    .err_o(rx_err));
  always @(posedge clk_i)
  begin
    cycles++;
    if (transmit_irq_o === 1'b1)
      irqs++;
    if (cycles == 40000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    // Only the bench timeout ends a wait for ack
    do
    begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rx(input int n);
    while (rx_count < n)
      @(posedge clk_i);
  endtask : wait_rx
  task automatic t_reset;
    wb(1'b0, UEC_MODE_OFS, 16'h0000);
    chk(q, 32'h0);
    wb(1'b0, UEC_STAT_OFS, 16'h0000);
    chk(q, 32'h0110);
    chk(tx_oe, 32'h0);
    wb(1'b0, 8'h1C, 16'h0000);
    chk(q, 32'h0);
  endtask : t_reset
  task automatic t_formats;
    logic [8:0] d;
    for (int f = 0; f < 4; f++)
      for (int st = 0; st < 2; st++)
      begin
        nbits = (f == 3) ? 9 : 8;
        par = (f == 3) ? 0 : f;
        stops = st + 1;
        d = (f == 3) ? 9'h1A5 : {1'b0, 8'hA6 ^ 8'(f)};
        wb(1'b1, UEC_MODE_OFS, 16'h8000 | 16'(f << 1) | 16'(st));
        wb(1'b1, UEC_STAT_OFS, 16'h0400);
        base = rx_count;
        wb(1'b1, UEC_TXD_OFS, {7'h00, d});
        wait_rx(base + 1);
        chk(rx_data, d);
        chk(rx_err, 32'h0);
        chk(tx_w & tx_oe, 32'h1);
      end
    nbits = 8;
    par = 0;
    stops = 1;
  endtask : t_formats
  task automatic t_queue(input logic isel);
    wb(1'b1, UEC_MODE_OFS, 16'h8000);
    wb(1'b1, UEC_STAT_OFS, {isel, 15'h0000});
    base = rx_count;
    irqs = 0;
    for (int i = 0; i < 5; i++)
      wb(1'b1, UEC_TXD_OFS, 16'h0030 + 16'(i));
    wb(1'b0, UEC_STAT_OFS, 16'h0000);
    chk(q[UEC_S_FULL], 32'h1);
    wb(1'b1, UEC_STAT_OFS, {isel, 15'h0400});
    for (int i = 0; i < 4; i++)
    begin
      wait_rx(base + i + 1);
      chk(rx_data, 32'h30 + i);
    end
    repeat (300) @(posedge clk_i);
    chk(rx_count - base, 32'h4);
    chk(irqs, isel ? 32'h1 : 32'h4);
  endtask : t_queue
  task automatic t_alt;
    bit_clks = 48;
    wb(1'b1, UEC_RATE_OFS, 16'h0002);
    wb(1'b1, UEC_MODE_OFS, 16'h8400);
    wb(1'b1, UEC_STAT_OFS, 16'h0400);
    base = rx_count;
    wb(1'b1, UEC_TXD_OFS, 16'h005A);
    wait_rx(base + 1);
    chk(rx_data, 32'h5A);
    chk({tx_oe, atx_oe}, 32'h1);
  endtask : t_alt
  task automatic t_disable;
    bit_clks = 64;
    par = 2;
    wb(1'b1, UEC_RATE_OFS, 16'h0003);
    wb(1'b1, UEC_MODE_OFS, 16'h8005);
    wb(1'b1, UEC_STAT_OFS, 16'h8000);
    wb(1'b1, UEC_TXD_OFS, 16'h0011);
    wb(1'b1, UEC_TXD_OFS, 16'h0022);
    wb(1'b1, UEC_MODE_OFS, 16'h0005);
    wb(1'b0, UEC_MODE_OFS, 16'h0000);
    chk(q, 32'h0005);
    wb(1'b0, UEC_RATE_OFS, 16'h0000);
    chk(q, 32'h0003);
    wb(1'b0, UEC_STAT_OFS, 16'h0000);
    chk(q, 32'h8110);
    wb(1'b1, UEC_MODE_OFS, 16'h8005);
    wb(1'b1, UEC_STAT_OFS, 16'h8400);
    base = rx_count;
    repeat (900) @(posedge clk_i);
    chk(rx_count - base, 32'h0);
    wb(1'b1, UEC_TXD_OFS, 16'h0033);
    repeat (100) @(posedge clk_i);
    wb(1'b1, UEC_MODE_OFS, 16'h0005);
    // Pin ownership is registered one edge after the mode write lands
    repeat (2) @(posedge clk_i);
    chk(tx_oe, 32'h0);
    repeat (900) @(posedge clk_i);
    wb(1'b1, UEC_RATE_OFS, 16'h0000);
    bit_clks = 16;
    par = 0;
  endtask : t_disable
  task automatic t_break;
    int lows;
    lows = 0;
    wb(1'b1, UEC_MODE_OFS, 16'h8000);
    wb(1'b1, UEC_STAT_OFS, 16'h0C00);
    irqs = 0;
    // Held for thirteen bit times before release
    repeat (13 * 16)
    begin
      @(posedge clk_i);
      lows += (tx_w === 1'b0);
    end
    chk(lows, 32'd208);
    wb(1'b1, UEC_STAT_OFS, 16'h0400);
    repeat (32) @(posedge clk_i);
    chk(tx_w, 32'h1);
    chk(irqs, 32'h0);
  endtask : t_break
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_formats();
    t_queue(1'b0);
    t_queue(1'b1);
    t_alt();
    t_disable();
    t_break();
    stop_test();
  end
endmodule : uart_enable_config_transmit_tb_top
